// ---- hdl/brs_top.sv ----
// Board reset sequencer with management bus target
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Power good forwards board ready; all device resets stay asserted.
// - Boot release is passed on and device resets whose software reset bit is clear are released.
// - Each device has its own software reset bit.
// - Isolation bit set blocks the processor boot release signal.
// - An output continuously mirrors the isolation bit.
// - Isolation bit resets to zero so boot release passes by default.
// - Registers are reached as a target on the management serial bus.
module brs_top (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         power_good,
   input  wire logic                         boot_release,
   input  wire logic                         scl_in,
   input  wire logic                         sda_in,
   output logic                              sda_out,
   output logic                              sda_oe_n,
   output logic                              board_ready_signal,
   output logic                              boot_release_out,
   output logic                              iso_state,
   output logic [brs_pkg::NUM_DEV-1:0]       dev_rst_n
);

   logic [brs_pkg::PIN_W-1:0]  pin_f;
   logic                       pg_f;
   logic                       boot_f;
   logic                       scl;
   logic                       sda;
   logic [1:0]                 bus_p_q;
   logic                       rise;
   logic                       fall;
   logic                       start;
   logic                       stop;

   brs_pin_sync #(
      .W       (brs_pkg::PIN_W),
      .RST_VAL (brs_pkg::PIN_RST)
   ) u_sync (
      .clk   (clk),
      .rst   (rst),
      .din   ({sda_in, scl_in, boot_release, power_good}),
      .flt_q (pin_f)
   );

   assign pg_f   = pin_f[brs_pkg::PIN_PG];
   assign boot_f = pin_f[brs_pkg::PIN_BOOT];
   assign scl    = pin_f[brs_pkg::PIN_SCL];
   assign sda    = pin_f[brs_pkg::PIN_SDA];
   assign rise   = scl & ~bus_p_q[0];
   assign fall   = ~scl & bus_p_q[0];
   assign start  = scl & bus_p_q[0] & bus_p_q[1] & ~sda;
   assign stop   = scl & bus_p_q[0] & ~bus_p_q[1] & sda;

   // Bus target
   brs_pkg::brs_i2c_st_t st_q, st_d;
   logic [3:0]           cnt_q, cnt_d;
   logic [7:0]           sh_q, sh_d;
   logic [7:0]           tx_q, tx_d;
   logic [7:0]           ptr_q, ptr_d;
   logic                 rw_q, rw_d;
   logic                 oe_n_d;
   brs_pkg::brs_wr_t     wr_q, wr_d;
   logic [7:0]           rdata;

   always_comb begin
      st_d        = st_q;
      cnt_d       = cnt_q;
      sh_d        = sh_q;
      tx_d        = tx_q;
      ptr_d       = ptr_q;
      rw_d        = rw_q;
      oe_n_d      = sda_oe_n;
      wr_d        = '0;
      wr_d.addr   = ptr_q;
      wr_d.data   = sh_q;
      if (stop) begin
         st_d   = brs_pkg::I2C_IDLE;
         oe_n_d = 1'b1;
      end else if (start) begin
         st_d   = brs_pkg::I2C_HDR;
         cnt_d  = 4'h0;
         oe_n_d = 1'b1;
      end else begin
         if (rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
         end
         case (st_q)
            brs_pkg::I2C_HDR: begin
               if (fall && cnt_q == brs_pkg::BYTE_BITS) begin
                  if (sh_q[7:1] == brs_pkg::I2C_ADDR) begin
                     oe_n_d = 1'b0;
                     rw_d   = sh_q[0];
                     st_d   = brs_pkg::I2C_ADDR_ACK;
                  end else begin
                     st_d   = brs_pkg::I2C_IDLE;
                  end
               end
            end
            brs_pkg::I2C_ADDR_ACK: begin
               if (fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     tx_d   = rdata;
                     oe_n_d = rdata[7];
                     st_d   = brs_pkg::I2C_RD;
                  end else begin
                     oe_n_d = 1'b1;
                     st_d   = brs_pkg::I2C_PTR;
                  end
               end
            end
            brs_pkg::I2C_PTR: begin
               if (fall && cnt_q == brs_pkg::BYTE_BITS) begin
                  ptr_d  = sh_q;
                  oe_n_d = 1'b0;
                  st_d   = brs_pkg::I2C_PTR_ACK;
               end
            end
            brs_pkg::I2C_WR: begin
               if (fall && cnt_q == brs_pkg::BYTE_BITS) begin
                  wr_d.en = 1'b1;
                  oe_n_d  = 1'b0;
                  st_d    = brs_pkg::I2C_WR_ACK;
               end
            end
            brs_pkg::I2C_PTR_ACK, brs_pkg::I2C_WR_ACK: begin
               if (fall) begin
                  oe_n_d = 1'b1;
                  cnt_d  = 4'h0;
                  st_d   = brs_pkg::I2C_WR;
                  if (st_q == brs_pkg::I2C_WR_ACK) begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            brs_pkg::I2C_RD: begin
               if (fall) begin
                  if (cnt_q == brs_pkg::BYTE_BITS) begin
                     oe_n_d = 1'b1;
                     st_d   = brs_pkg::I2C_RD_ACK;
                  end else begin
                     tx_d   = {tx_q[6:0], 1'b0};
                     oe_n_d = tx_q[6];
                  end
               end
            end
            brs_pkg::I2C_RD_ACK: begin
               // Pointer moves at the ack rise so rdata is ready by the fall
               if (rise) begin
                  if (sda) begin
                     st_d = brs_pkg::I2C_IDLE;
                  end else begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (fall) begin
                  cnt_d  = 4'h0;
                  tx_d   = rdata;
                  oe_n_d = rdata[7];
                  st_d   = brs_pkg::I2C_RD;
               end
            end
            default: begin
               oe_n_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q     <= brs_pkg::I2C_IDLE;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         tx_q     <= 8'h00;
         ptr_q    <= 8'h00;
         rw_q     <= 1'b0;
         sda_oe_n <= 1'b1;
         sda_out  <= 1'b0;
         wr_q     <= '0;
         bus_p_q  <= 2'h3;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         sh_q     <= sh_d;
         tx_q     <= tx_d;
         ptr_q    <= ptr_d;
         rw_q     <= rw_d;
         sda_oe_n <= oe_n_d;
         sda_out  <= 1'b0;
         wr_q     <= wr_d;
         bus_p_q  <= {sda, scl};
      end
   end

   // Registers
   logic [7:0]                 iso_q, iso_d;
   logic [brs_pkg::NUM_DEV-1:0] sw_q, sw_d;
   brs_pkg::brs_seq_t          seq_q, seq_d;

   always_comb begin
      iso_d = iso_q;
      sw_d  = sw_q;
      if (wr_q.en && wr_q.addr == brs_pkg::ISO_OFF) begin
         iso_d = wr_q.data;
      end
      if (wr_q.en && wr_q.addr == brs_pkg::DEVRST_OFF) begin
         sw_d = wr_q.data[brs_pkg::NUM_DEV-1:0];
      end
      rdata = brs_pkg::UNMAPPED_VAL;
      case (ptr_q)
         brs_pkg::ISO_OFF:    rdata = iso_q;
         brs_pkg::DEVRST_OFF: rdata = sw_q;
         brs_pkg::STATUS_OFF: begin
            rdata[brs_pkg::STAT_PG_BIT]    = pg_f;
            rdata[brs_pkg::STAT_BOOT_BIT]  = boot_f;
            rdata[brs_pkg::STAT_READY_BIT] = board_ready_signal;
            rdata[brs_pkg::STAT_RUN_BIT]   = boot_release_out;
         end
         default:             rdata = brs_pkg::UNMAPPED_VAL;
      endcase
   end

   // Sequencer
   logic                        boot_eff;
   logic                        pass_d;
   logic                        ready_d;
   logic [brs_pkg::NUM_DEV-1:0] dev_d;

   always_comb begin
      // Isolation freezes the passed level so processor self-resets stay local
      boot_eff = iso_q[brs_pkg::ISO_BIT] ? boot_release_out : boot_f;
      seq_d    = seq_q;
      if (!pg_f) begin
         seq_d = brs_pkg::SEQ_WAIT_PWR;
      end else begin
         case (seq_q)
            brs_pkg::SEQ_WAIT_PWR: seq_d = brs_pkg::SEQ_READY;
            brs_pkg::SEQ_READY:    if (boot_eff) seq_d = brs_pkg::SEQ_RUN;
            brs_pkg::SEQ_RUN:      if (!boot_eff) seq_d = brs_pkg::SEQ_READY;
            default:               seq_d = brs_pkg::SEQ_WAIT_PWR;
         endcase
      end
      ready_d = (seq_d != brs_pkg::SEQ_WAIT_PWR);
      pass_d  = (seq_d == brs_pkg::SEQ_RUN);
   end

   for (genvar i = 0; i < brs_pkg::NUM_DEV; i++) begin : g_dev
      assign dev_d[i] = ~(sw_q[i] | ~pass_d);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         iso_q              <= brs_pkg::ISO_RST;
         sw_q               <= brs_pkg::DEVRST_RST[brs_pkg::NUM_DEV-1:0];
         seq_q              <= brs_pkg::SEQ_WAIT_PWR;
         board_ready_signal <= 1'b0;
         boot_release_out   <= 1'b0;
         iso_state          <= 1'b0;
         dev_rst_n          <= '0;
      end else begin
         iso_q              <= iso_d;
         sw_q               <= sw_d;
         seq_q              <= seq_d;
         board_ready_signal <= ready_d;
         boot_release_out   <= pass_d;
         iso_state          <= iso_d[brs_pkg::ISO_BIT];
         dev_rst_n          <= dev_d;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_dev_write;
      wr_q.en && wr_q.addr == brs_pkg::DEVRST_OFF;
   endsequence

   sequence s_quiet_then_run;
      !wr_q.en ##1 boot_release_out;
   endsequence

   a_ready_after_pg: assert property (
      seq_q == brs_pkg::SEQ_WAIT_PWR && pg_f |=> board_ready_signal && !boot_release_out)
      else $error("board ready not raised after power good");
   a_hold_before_boot: assert property (
      !boot_release_out |-> dev_rst_n == '0)
      else $error("device reset released before boot release");
   a_boot_releases: assert property (
      seq_q == brs_pkg::SEQ_READY && pg_f && boot_f && !iso_q[brs_pkg::ISO_BIT]
      |=> boot_release_out && dev_rst_n == ~$past(sw_q))
      else $error("boot release did not free devices");
   a_soft_reset: assert property (
      s_dev_write ##1 s_quiet_then_run |-> dev_rst_n == ~$past(wr_q.data[brs_pkg::NUM_DEV-1:0], 2))
      else $error("software reset bits not applied");
   a_iso_blocks: assert property (
      iso_q[brs_pkg::ISO_BIT] && boot_release_out && pg_f |=> boot_release_out)
      else $error("isolated boot release dropped");
   a_iso_mirror: assert property (
      iso_state == iso_q[brs_pkg::ISO_BIT])
      else $error("isolation output differs from register");
   a_iso_reset: assert property (
      $fell(rst) |-> iso_q == brs_pkg::ISO_RST && !iso_state)
      else $error("isolation bit not cleared by reset");
   a_addr_ack: assert property (
      st_q == brs_pkg::I2C_HDR && fall && !start && !stop && cnt_q == brs_pkg::BYTE_BITS
      && sh_q[7:1] == brs_pkg::I2C_ADDR |=> !sda_oe_n ##1 st_q == brs_pkg::I2C_ADDR_ACK)
      else $error("own address not acknowledged");
   a_ready_synced: assert property (
      $rose(board_ready_signal) |-> $past(pg_f))
      else $error("board ready without synchronised power good");

endmodule
`default_nettype wire

// ---- hdl/brs_pkg.sv ----
// Shared constants and types for the board reset sequencer
`default_nettype none
package brs_pkg;

   localparam int unsigned NUM_DEV        = 8;

   // Target address on the management bus; value is arbitrary
   localparam logic [6:0]  I2C_ADDR       = 7'h31;

   // Register map
   localparam logic [7:0]  ISO_OFF        = 8'h0b;
   localparam logic [7:0]  DEVRST_OFF     = 8'h0c;
   localparam logic [7:0]  STATUS_OFF     = 8'h0d;
   localparam logic [7:0]  ISO_RST        = 8'h00;
   localparam logic [7:0]  DEVRST_RST     = 8'h00;
   localparam logic [7:0]  UNMAPPED_VAL   = 8'h00;
   localparam int unsigned ISO_BIT        = 0;

   // Status register fields
   localparam int unsigned STAT_PG_BIT    = 0;
   localparam int unsigned STAT_BOOT_BIT  = 1;
   localparam int unsigned STAT_READY_BIT = 2;
   localparam int unsigned STAT_RUN_BIT   = 3;

   // Pin synchroniser lanes and idle levels
   localparam int unsigned PIN_W          = 4;
   localparam int unsigned PIN_PG         = 0;
   localparam int unsigned PIN_BOOT       = 1;
   localparam int unsigned PIN_SCL        = 2;
   localparam int unsigned PIN_SDA        = 3;
   localparam logic [3:0]  PIN_RST        = 4'hc;

   localparam logic [3:0]  BYTE_BITS      = 4'h8;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } brs_wr_t;

   typedef enum logic [1:0] {
      SEQ_WAIT_PWR = 2'h0,
      SEQ_READY    = 2'h1,
      SEQ_RUN      = 2'h2
   } brs_seq_t;

   typedef enum logic [3:0] {
      I2C_IDLE     = 4'h0,
      I2C_HDR      = 4'h1,
      I2C_ADDR_ACK = 4'h2,
      I2C_PTR      = 4'h3,
      I2C_PTR_ACK  = 4'h4,
      I2C_WR       = 4'h5,
      I2C_WR_ACK   = 4'h6,
      I2C_RD       = 4'h7,
      I2C_RD_ACK   = 4'h8
   } brs_i2c_st_t;

endpackage
`default_nettype wire

// ---- hdl/brs_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module brs_pin_sync #(
   parameter int unsigned         W       = 1,
   parameter logic [W-1:0]        RST_VAL = '0
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [W-1:0]      din,
   output logic      [W-1:0]      flt_q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] flt_d;

   // Level moves only once stages two and three agree
   always_comb begin
      flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         flt_q <= RST_VAL;
      end else begin
         s1_q  <= din;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         flt_q <= flt_d;
      end
   end

   a_filter_agree: assert property (@(posedge clk) disable iff (rst)
      ((flt_q ^ $past(flt_q)) & ($past(s2_q) ^ $past(s3_q))) == '0)
      else $error("filtered pin changed without stage agreement");

endmodule
`default_nettype wire

// ---- testbench/brs_host_model.sv ----
// Host board and supply monitor model driving the sequencer pins
`timescale 1ns/10ps
`default_nettype none
module brs_host_model (
   input  wire logic clk,
   input  wire logic sda_oe_n,
   output logic      power_good,
   output logic      boot_release,
   output logic      scl_in,
   output logic      sda_in
);
   logic sda_m;
   // Pull-up wins unless a side pulls low
   assign sda_in = sda_m & sda_oe_n;
   initial begin
      power_good = 1'b0;
      boot_release = 1'b0;
      scl_in = 1'b1;
      sda_m = 1'b1;
   end
   // Raised only once the bench judges every rail good
   task automatic set_pg(input logic v);
      @(negedge clk);
      power_good = v;
   endtask
   // One-cycle pulse, shorter than the pin filter accepts
   task automatic glitch_pg();
      @(negedge clk);
      power_good = 1'b1;
      @(negedge clk);
      power_good = 1'b0;
   endtask
   task automatic set_boot(input logic v);
      @(negedge clk);
      boot_release = v;
   endtask
   // Phases of 8 clocks outlast the pin synchroniser
   task automatic step(input logic c, input logic d);
      repeat (8) @(negedge clk);
      scl_in = c;
      sda_m = d;
   endtask
   task automatic bit_x(input logic b, output logic r);
      step(1'b0, sda_m);
      step(1'b0, b);
      step(1'b1, b);
      repeat (8) @(negedge clk);
      r = sda_in;
   endtask
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic tx(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(v[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // Single byte read, always closed by a not-acknowledge
   task automatic rx(output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         v[i] = r;
      end
      bit_x(1'b1, r);
   endtask
   task automatic wr(input logic [6:0] t, input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      tx({t, 1'b0}, k0);
      tx(a, k1);
      tx(d, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   task automatic rd(input logic [6:0] t, input logic [7:0] a, output logic [7:0] v, output logic ok);
      logic k0, k1, k2;
      start();
      tx({t, 1'b0}, k0);
      tx(a, k1);
      start();
      tx({t, 1'b1}, k2);
      rx(v);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire

// ---- testbench/board_reset_sequencer_test.sv ----
// Self-checking bench for the board reset sequencer
`timescale 1ns/10ps
`default_nettype none
module board_reset_sequencer_test;
   localparam int LIMIT = 60000;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        pg, boot, scl, sda, oe_n, rdy, bout, iso, ok, sdo;
   logic [7:0]  dev_n, v;
   logic [31:0] rnd = 32'h3;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          pg_m = 0, boot_m = 0, iso_m = 0, sw_m = 0, run_m = 0;

   always #20 clk = ~clk;

   brs_top uut (.clk(clk), .rst(rst), .power_good(pg), .boot_release(boot), .scl_in(scl),
      .sda_in(sda), .sda_out(sdo), .sda_oe_n(oe_n), .board_ready_signal(rdy),
      .boot_release_out(bout), .iso_state(iso), .dev_rst_n(dev_n));
   brs_host_model host (.clk(clk), .sda_oe_n(oe_n), .power_good(pg), .boot_release(boot),
      .scl_in(scl), .sda_in(sda));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Reference model: sequencing state and expected pins
   task automatic settle();
      repeat (8) @(negedge clk);
      if (pg_m == 0) run_m = 0;
      else if (iso_m[0] == 1'b0) run_m = boot_m;
      chk(rdy, pg_m[0]);
      chk(bout, run_m[0]);
      chk(iso, iso_m[0]);
      chk(dev_n, run_m[0] ? ~sw_m[7:0] : 8'h00);
      chk(sdo, 8'h00);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      host.wr(brs_pkg::I2C_ADDR, a, d, ok);
      chk(ok, 8'h01);
      if (a == brs_pkg::ISO_OFF) iso_m = d;
      if (a == brs_pkg::DEVRST_OFF) sw_m = d;
      settle();
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      host.rd(brs_pkg::I2C_ADDR, a, v, ok);
      chk(ok, 8'h01);
      chk(v, exp);
   endtask
   function automatic logic [7:0] stat();
      return {4'h0, run_m[0], pg_m[0], boot_m[0], pg_m[0]};
   endfunction
   // Boot release moves before power good, so a drop never races a rise
   task automatic pins(input int p, input int b);
      pg_m = p;
      boot_m = b;
      host.set_boot(boot_m[0]);
      host.set_pg(pg_m[0]);
      settle();
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      settle();
      rreg(brs_pkg::ISO_OFF, brs_pkg::ISO_RST);
      rreg(brs_pkg::DEVRST_OFF, brs_pkg::DEVRST_RST);
      // One-cycle glitch on power good must not count
      host.glitch_pg();
      settle();
      pins(0, 1);
      pins(1, 0);
      pins(1, 1);
      repeat (4) begin
         rnd = xs(rnd);
         wreg(brs_pkg::DEVRST_OFF, rnd[7:0]);
         rreg(brs_pkg::DEVRST_OFF, rnd[7:0]);
      end
      wreg(brs_pkg::ISO_OFF, 8'h01);
      rreg(brs_pkg::ISO_OFF, 8'h01);
      // Boot release drop is blocked while isolated
      pins(1, 0);
      rreg(brs_pkg::STATUS_OFF, stat());
      host.wr(brs_pkg::I2C_ADDR, brs_pkg::STATUS_OFF, 8'hff, ok);
      rreg(brs_pkg::STATUS_OFF, stat());
      host.wr(brs_pkg::I2C_ADDR, 8'h20, 8'h5a, ok);
      rreg(8'h20, brs_pkg::UNMAPPED_VAL);
      wreg(brs_pkg::ISO_OFF, 8'h00);
      // Foreign address must be ignored
      host.wr(brs_pkg::I2C_ADDR ^ 7'h01, brs_pkg::ISO_OFF, 8'h01, ok);
      chk(ok, 8'h00);
      settle();
      pins(1, 1);
      // Reset in mid-run must clear an isolation bit set just before
      wreg(brs_pkg::ISO_OFF, 8'h01);
      @(negedge clk);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      iso_m = 0;
      sw_m = 0;
      settle();
      rreg(brs_pkg::ISO_OFF, brs_pkg::ISO_RST);
      pins(0, 1);
      summarize();
   end
endmodule
`default_nettype wire
